// ### core/ptcp_pkg.sv
package ptcp_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int CNT_W = 10;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_DUTY_LO = 8'h10;
  localparam logic [7:0] OFS_DUTY_HI = 8'h14;
  localparam logic [7:0] OFS_PER_LO = 8'h18;
  localparam logic [7:0] OFS_PER_HI = 8'h1c;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int C0_PAUSE = 7;
  localparam int C0_ON = 3;
  localparam int C1_MODE = 6;
  localparam int C1_PIN = 4;
  localparam int C1_OC = 3;
  localparam int C1_INV = 2;
  localparam int C1_CAPS = 1;
  localparam int C1_CCLR = 0;
  localparam int FL_A = 0;
  localparam int FL_P = 1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_CNT = 10'h000;
  // ----------------------------------------
  // mode and pin codes
  // ----------------------------------------
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TC = 2'h3;
  localparam logic [1:0] PIN_KEEP = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [1:0] PIN_TOG = 2'h3;
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_ON = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
endpackage

// ### core/ptcp_timer.sv
`timescale 1ns/10ps
module ptcp_timer (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // counter clock tick
  input wire logic i_count_tick,
  // pins
  input wire logic i_timer_pin_in,
  input wire logic i_external_clock_pin,
  output logic o_timer_pin_out,
  output logic o_timer_pin_oe,
  output logic o_capture_trigger
);
  import ptcp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] cnt_q;
  logic [9:0] duty_q;
  logic [9:0] per_q;
  logic [7:0] duty_stage_q;
  logic [7:0] per_stage_q;
  logic flag_a_q;
  logic flag_p_q;
  logic on_prev_q;
  logic cmp_lvl_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic on_b;
  logic rise;
  logic adv;
  logic [1:0] mode;
  logic [1:0] pin;
  logic oc;
  logic inv;
  logic [9:0] inc;
  logic hit_a;
  logic hit_p;
  logic clr_on_a;
  logic set_a;
  logic set_p;
  logic full;
  logic pwm_act;
  logic pwm_lvl;
  logic acc;
  logic wr_en;
  logic fl_clr_a;
  logic fl_clr_p;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFS_CTRL0: w[7:0] = ctrl0_q;
      OFS_CTRL1: w[7:0] = ctrl1_q;
      OFS_CNT_LO: w[7:0] = cnt_q[7:0];
      OFS_CNT_HI: w[1:0] = cnt_q[9:8];
      OFS_DUTY_LO: w[7:0] = duty_stage_q;
      OFS_DUTY_HI: w[1:0] = duty_q[9:8];
      OFS_PER_LO: w[7:0] = per_stage_q;
      OFS_PER_HI: w[1:0] = per_q[9:8];
      OFS_FLAGS: w[1:0] = {flag_p_q, flag_a_q};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  assign on_b = ctrl0_q[C0_ON];
  assign mode = ctrl1_q[C1_MODE +: 2];
  assign pin = ctrl1_q[C1_PIN +: 2];
  assign oc = ctrl1_q[C1_OC];
  assign inv = ctrl1_q[C1_INV];
  assign rise = on_b && !on_prev_q;
  assign adv = i_clk_en && on_b && !ctrl0_q[C0_PAUSE] && i_count_tick && !rise;
  assign inc = cnt_q + 10'h001;
  assign hit_a = (duty_q != RST_CNT) && (inc == duty_q);
  assign hit_p = (per_q != RST_CNT) && (inc == per_q);
  assign clr_on_a = ctrl1_q[C1_CCLR] && (mode == MODE_CMP || mode == MODE_TC);
  assign set_a = adv && hit_a;
  assign set_p = adv && hit_p && !clr_on_a;
  assign full = (per_q != RST_CNT) && (duty_q >= per_q);
  assign pwm_act = full || (cnt_q < duty_q);
  assign acc = i_hsel && i_htrans[1] && i_hready;
  assign wr_en = i_clk_en && wr_q;
  assign fl_clr_a = wr_en && addr_q == OFS_FLAGS && i_hwdata[FL_A];
  assign fl_clr_p = wr_en && addr_q == OFS_FLAGS && i_hwdata[FL_P];

  always_comb begin
    unique case (pin)
      PWM_OFF: pwm_lvl = !oc;
      PWM_ON: pwm_lvl = oc;
      PWM_WAVE: pwm_lvl = pwm_act ? oc : !oc;
      default: pwm_lvl = !oc;
    endcase
  end

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= RST_BYTE;
    end else if (i_clk_en) begin
      wr_q <= acc && i_hwrite;
      rd_q <= acc && !i_hwrite;
      if (acc) begin
        addr_q <= i_haddr[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
    end else if (i_clk_en) begin
      o_hresp <= 1'b0;
      if (acc && !i_hwrite) begin
        o_hreadyout <= 1'b0;
      end else begin
        o_hreadyout <= 1'b1;
      end
      if (rd_q) begin
        o_hrdata <= rd_word(addr_q);
      end
    end
  end

  // ----------------------------------------
  // control and compare registers
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl0_q <= RST_BYTE;
      ctrl1_q <= RST_BYTE;
    end else if (wr_en) begin
      if (addr_q == OFS_CTRL0) begin
        ctrl0_q <= {i_hwdata[7:3], 3'h0};
      end
      if (addr_q == OFS_CTRL1) begin
        ctrl1_q <= i_hwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      duty_stage_q <= RST_BYTE;
      per_stage_q <= RST_BYTE;
      duty_q <= RST_CNT;
      per_q <= RST_CNT;
    end else if (wr_en) begin
      unique case (addr_q)
        OFS_DUTY_LO: duty_stage_q <= i_hwdata[7:0];
        OFS_DUTY_HI: duty_q <= {i_hwdata[1:0], duty_stage_q};
        OFS_PER_LO: per_stage_q <= i_hwdata[7:0];
        OFS_PER_HI: per_q <= {i_hwdata[1:0], per_stage_q};
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= RST_CNT;
      on_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      on_prev_q <= on_b;
      if (rise) begin
        cnt_q <= RST_CNT;
      end else if (adv) begin
        if (clr_on_a ? hit_a : hit_p) begin
          cnt_q <= RST_CNT;
        end else begin
          cnt_q <= inc;
        end
      end
    end
  end

  // ----------------------------------------
  // match flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else if (i_clk_en) begin
      if (set_a) begin
        flag_a_q <= 1'b1;
      end else if (fl_clr_a) begin
        flag_a_q <= 1'b0;
      end
      if (set_p) begin
        flag_p_q <= 1'b1;
      end else if (fl_clr_p) begin
        flag_p_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin logic
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cmp_lvl_q <= 1'b0;
    end else if (i_clk_en) begin
      if (rise) begin
        cmp_lvl_q <= oc;
      end else if (set_a && mode == MODE_CMP) begin
        unique case (pin)
          PIN_KEEP: cmp_lvl_q <= cmp_lvl_q;
          PIN_LOW: cmp_lvl_q <= 1'b0;
          PIN_HIGH: cmp_lvl_q <= 1'b1;
          PIN_TOG: cmp_lvl_q <= !cmp_lvl_q;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_timer_pin_out <= 1'b0;
      o_timer_pin_oe <= 1'b0;
      o_capture_trigger <= 1'b0;
    end else if (i_clk_en) begin
      o_capture_trigger <= ctrl1_q[C1_CAPS] ? i_external_clock_pin : i_timer_pin_in;
      unique case (mode)
        MODE_CMP: begin
          o_timer_pin_out <= cmp_lvl_q ^ inv;
          o_timer_pin_oe <= 1'b1;
        end
        MODE_PWM: begin
          o_timer_pin_out <= pwm_lvl ^ inv;
          o_timer_pin_oe <= 1'b1;
        end
        default: begin
          o_timer_pin_out <= 1'b0;
          o_timer_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  logic duty_hi_wr;
  assign duty_hi_wr = wr_en && addr_q == OFS_DUTY_HI;

  sequence s_pwm_forced;
    (mode == MODE_PWM && pin == PWM_OFF && i_clk_en && $stable(ctrl1_q))[*2];
  endsequence

  sequence s_tc_steady;
    (mode == MODE_TC && i_clk_en)[*2];
  endsequence

  sequence s_cmp_steady;
    (mode == MODE_CMP && i_clk_en)[*2];
  endsequence

  sequence s_read_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  a_cnt_rise_zero: assert property (i_clk_en && rise |=> cnt_q == RST_CNT)
    else $error("counter not zeroed on enable rise");
  a_cnt_off_hold: assert property (i_clk_en && !on_b && !wr_en |=> $stable(cnt_q))
    else $error("counter moved while off");
  a_no_p_flag: assert property (adv && clr_on_a && !flag_p_q |=> !flag_p_q)
    else $error("p flag raised with clear on a");
  a_no_a_zero: assert property (adv && duty_q == RST_CNT && !flag_a_q |=> !flag_a_q)
    else $error("a flag raised with zero duty");
  a_pwm_period: assert property (adv && mode == MODE_PWM && per_q != RST_CNT
    && cnt_q == per_q - 10'h001 |=> cnt_q == RST_CNT)
    else $error("pwm period clear missed");
  a_pwm_wrap: assert property (adv && mode == MODE_PWM && per_q == RST_CNT
    && cnt_q == CNT_MAX |=> cnt_q == RST_CNT)
    else $error("pwm 1024 count wrap missed");
  a_tc_no_drive: assert property (s_tc_steady |-> !o_timer_pin_oe)
    else $error("pin driven in timer mode");
  a_pwm_forced: assert property (s_pwm_forced |-> o_timer_pin_out == (!oc ^ inv))
    else $error("forced inactive level wrong");
  a_init_level: assert property (i_clk_en && rise && mode == MODE_CMP
    ##1 (i_clk_en && !set_a && $stable(ctrl1_q))[*2] |-> o_timer_pin_out == (oc ^ inv))
    else $error("initial pin level wrong");
  a_duty_atomic: assert property (!$stable(duty_q) |-> $past(duty_hi_wr))
    else $error("duty changed without high byte write");
  a_flag_sticky: assert property (flag_a_q && !fl_clr_a |=> flag_a_q)
    else $error("a flag dropped without clear");
  a_flag_a_set: assert property (set_a |=> flag_a_q)
    else $error("a flag not set on duty match");
  a_flag_p_set: assert property (set_p |=> flag_p_q)
    else $error("p flag not set on period match");
  a_clr_on_a: assert property (adv && clr_on_a && hit_a |=> cnt_q == RST_CNT)
    else $error("counter not cleared on a match");
  a_clr_on_p: assert property (adv && !clr_on_a && hit_p |=> cnt_q == RST_CNT)
    else $error("counter not cleared on p match");
  a_cmp_toggle: assert property (set_a && mode == MODE_CMP && pin == PIN_TOG
    |=> cmp_lvl_q != $past(cmp_lvl_q))
    else $error("compare pin did not toggle");
  a_p_keeps_pin: assert property (adv && hit_p && !hit_a |=> $stable(cmp_lvl_q))
    else $error("p match moved compare pin");
  a_pwm_forced_run: assert property (adv && mode == MODE_PWM && pin != PWM_WAVE
    && !hit_p |=> cnt_q == $past(inc))
    else $error("pwm counter stalled while pin forced");
  a_cmp_drive: assert property (s_cmp_steady |-> o_timer_pin_oe)
    else $error("pin not driven in compare mode");
  a_read_wait: assert property (i_clk_en && acc && !i_hwrite
    ##1 i_clk_en |-> s_read_wait)
    else $error("read wait state wrong");
endmodule

// ### verif/ptcp_pin_model.sv
`timescale 1ns/10ps
module ptcp_pin_model (
  // clock
  input wire logic i_clock,
  // timer side
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  // pin levels
  output logic o_timer_pin,
  output logic o_ext_clk_pin
);
  logic pat_q = 1'b0;
  // released pin shows a changing pattern
  always_ff @(posedge i_clock) begin
    pat_q <= ~pat_q;
  end
  assign o_timer_pin = i_pin_oe ? i_pin_out : pat_q;
  assign o_ext_clk_pin = ~pat_q ^ i_pin_out;
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import ptcp_pkg::*;
  logic i_clock = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, tick = 1;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rd;
  logic rdy, o_hresp, pin_out, pin_oe, cap, tpin, epin, lvl;
  logic [9:0] d, p;
  logic [1:0] pf;
  logic oc, inv;
  int n_errors = 0, total_checks = 0, hi_n, ed_n;
  ptcp_timer u_ptcp_timer (.i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(1'b1),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(rdy), .o_hrdata(o_hrdata),
    .o_hreadyout(rdy), .o_hresp(o_hresp), .i_count_tick(tick),
    .i_timer_pin_in(tpin), .i_external_clock_pin(epin), .o_timer_pin_out(pin_out),
    .o_timer_pin_oe(pin_oe), .o_capture_trigger(cap));
  ptcp_pin_model u_ptcp_pin_model (.i_clock(i_clock), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_timer_pin(tpin), .o_ext_clk_pin(epin));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    do @(posedge i_clock); while (rdy !== 1'b1 && ++t < 50);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clock); while (rdy !== 1'b1 && ++t < 50);
    rd = o_hrdata;
    if (t >= 50) n_errors++;
  endtask
  function automatic logic [31:0] c1(input logic [1:0] m, input logic [1:0] f,
      input logic o, input logic v, input logic s, input logic c);
    return {24'h0, m, f, o, v, s, c};
  endfunction
  function automatic int pwm_hi(input int dd, input int pp, input logic o, input logic v);
    int act;
    if (pp == 0) pp = 1024;
    act = (dd >= pp) ? pp : dd;
    act = o ? act : pp - act;
    return v ? pp - act : act;
  endfunction
  function automatic logic [31:0] exp_flags(input int dd, input int pp);
    return {30'h0, pp != 0, dd != 0 && (pp == 0 || dd <= pp)};
  endfunction
  task automatic setup(input logic [31:0] c, input logic [9:0] dv, input logic [9:0] pv);
    bus(OFS_CTRL0, 1, 32'h0);
    bus(OFS_DUTY_LO, 1, {24'h0, dv[7:0]});
    bus(OFS_DUTY_HI, 1, {30'h0, dv[9:8]});
    bus(OFS_PER_LO, 1, {24'h0, pv[7:0]});
    bus(OFS_PER_HI, 1, {30'h0, pv[9:8]});
    bus(OFS_CTRL1, 1, c);
    bus(OFS_FLAGS, 1, 32'h3);
    bus(OFS_CTRL0, 1, 32'h8);
  endtask
  task automatic measure(input int n);
    repeat (n / 2 + 8) @(negedge i_clock);
    hi_n = 0;
    ed_n = 0;
    lvl = pin_out;
    repeat (n) begin
      @(negedge i_clock);
      hi_n += (pin_out === 1'b1);
      ed_n += (pin_out !== lvl);
      lvl = pin_out;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(77));
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    for (int a = 0; a <= 8'h40; a += 4) begin
      bus(a[7:0], 0, 32'h0);
      chk(rd, 32'h0);
    end
    $display("test reset done");
    d = $urandom;
    p = $urandom;
    setup(c1(MODE_TC, 0, 0, 0, 0, 0), d, p);
    bus(OFS_DUTY_LO, 0, 0);
    chk(rd, {24'h0, d[7:0]});
    bus(OFS_DUTY_HI, 0, 0);
    chk(rd, {30'h0, d[9:8]});
    bus(OFS_PER_HI, 0, 0);
    chk(rd, {30'h0, p[9:8]});
    tick <= 1'b0;
    setup(c1(MODE_TC, 0, 0, 0, 0, 0), 0, 0);
    tick <= 1'b1;
    repeat (300) @(posedge i_clock);
    tick <= 1'b0;
    bus(OFS_CNT_LO, 0, 0);
    chk(rd, 32'h2b);
    bus(OFS_CNT_HI, 0, 0);
    chk(rd, 32'h1);
    chk(pin_oe, 1'b0);
    bus(OFS_CTRL0, 1, 32'h0);
    bus(OFS_CTRL0, 1, 32'h8);
    bus(OFS_CNT_LO, 0, 0);
    chk(rd, 32'h0);
    tick <= 1'b1;
    $display("test counter done");
    for (int i = 0; i < 8; i++) begin
      pf = i[1:0];
      oc = $urandom;
      inv = $urandom;
      p = 10 + $urandom % 20;
      d = 1 + $urandom % 8;
      setup(c1(i < 4 ? MODE_CMP : MODE_TC, pf, oc, inv, 0, 0), d, p);
      measure(4 * p);
      chk(ed_n, (pf == PIN_TOG && i < 4) ? 4 : 0);
      if (pf != PIN_TOG && i < 4) chk(pin_out, (pf == PIN_KEEP ? oc : pf[1]) ^ inv);
      chk(pin_oe, i < 4);
      bus(OFS_FLAGS, 0, 0);
      chk(rd, 32'h3);
    end
    setup(c1(MODE_CMP, PIN_TOG, 0, 0, 0, 1), 20, 10);
    measure(80);
    chk(ed_n, 4);
    bus(OFS_FLAGS, 0, 0);
    chk(rd, 32'h1);
    setup(c1(MODE_CMP, PIN_TOG, 0, 0, 0, 0), 0, 0);
    measure(1100);
    chk(ed_n, 0);
    bus(OFS_FLAGS, 0, 0);
    chk(rd & 32'h1, 32'h0);
    $display("test compare done");
    for (int i = 0; i < 8; i++) begin
      oc = $urandom;
      inv = $urandom;
      pf = (i == 5) ? 2'h3 : (i > 5) ? i[1:0] - 2'h2 : PWM_WAVE;
      p = (i == 0) ? 10'h0 : 10'(8 + $urandom % 30);
      d = (i == 0) ? 10'h100 : (i == 1) ? p + 3 : 10'($urandom % 40);
      setup(c1(MODE_PWM, pf, oc, inv, 0, $urandom), d, p);
      measure(p == 0 ? 2048 : 4 * p);
      if (pf == PWM_WAVE) chk(hi_n, pwm_hi(d, p, oc, inv) * (p == 0 ? 2 : 4));
      else chk(hi_n, ((pf == PWM_ON) ~^ oc) ^ inv ? 4 * p : 0);
      bus(OFS_FLAGS, 0, 0);
      chk(rd, exp_flags(d, p));
    end
    $display("test pwm done");
    for (int s = 0; s < 2; s++) begin
      bus(OFS_CTRL1, 1, c1(MODE_CMP, 0, 0, 0, s[0], 0));
      repeat (8) begin
        @(negedge i_clock);
        lvl = s ? epin : tpin;
        @(negedge i_clock);
        chk(cap, lvl);
      end
    end
    $display("test capture done");
    give_verdict();
  end
endmodule
